// *** tb/bus_load_model.sv ***
// terminated loads on the driven lines plus the mode strap
// assumes out_en high means the driver owns the line
`timescale 1ns/10ps
module bus_load_model (
	// driver side
	input  wire logic [1:0] out_data,
	input  wire logic [1:0] out_en,
	// strap and sensed lines
	input  wire logic       grounded,
	output logic            mode_ground_n,
	output logic      [1:0] line
);
	// an open strap reads high, a grounded one low
	assign mode_ground_n = !grounded;
	// a released line sinks to the termination, never keeps its last value
	assign line = out_data & out_en;
endmodule

// *** tb/latched_bus_driver_monitor.sv ***
// checker on the driver ports: apb answer timing and pin-to-output relations
// assumes ctrl stays zero whenever strobe is low
`timescale 1ns/10ps
module latched_bus_driver_monitor (
	// clock, reset and apb
	input wire logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr,
	input wire logic [31:0] prdata,
	// pins and outputs
	input wire logic        data_in_a, data_in_b, latch_clk, strobe, disable_in, mode_ground_n,
	input wire logic [1:0]  out_data, out_en
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// eight edges cover the pin sync plus latch and output stages
	logic [1:0] din;
	assign din = {data_in_b, data_in_a};
	wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("late ready");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	bad_read_a: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("bad error read");
	strobe_low_a: assert property (strobe[*8] |-> out_data == 2'h0)
		else $error("strobe ignored");
	pass_thru_a: assert property (((!disable_in || !mode_ground_n) && !strobe && !latch_clk
		&& $stable(din))[*8] |-> out_data == din) else $error("no pass through");
	hold_a: assert property ((latch_clk && !strobe && !disable_in)[*8] |-> $stable(out_data))
		else $error("latch leaks");
	float_out_a: assert property ((mode_ground_n && disable_in && !strobe && !latch_clk
		&& $stable(din))[*8] |-> out_data == 2'h0 && out_en == ~din) else $error("no float");
endmodule
bind latched_bus_driver latched_bus_driver_monitor u_mon (.core_clk, .sys_rst, .psel, .penable,
	.pwrite, .pready, .pslverr, .prdata, .data_in_a, .data_in_b, .latch_clk, .strobe,
	.disable_in, .mode_ground_n, .out_data, .out_en);

// *** tb/latched_bus_driver_test.sv ***
// self-checking bench: apb register calls, then pin steps seen through the loads
// assumes the load model resolves the driven lines
`timescale 1ns/10ps
module latched_bus_driver_test;
	import bus_driver_pkg::*;
	logic        core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic        data_in_a = 0, data_in_b = 0, latch_clk = 0, strobe = 1, disable_in = 0;
	logic        grounded = 0, mode_ground_n;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [1:0]  out_data, out_en, line;
	int          n_mismatch = 0, checked = 0;
	always #20 core_clk = ~core_clk;
	latched_bus_driver u_dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .data_in_a, .data_in_b, .latch_clk, .strobe, .disable_in,
		.mode_ground_n, .out_data, .out_en);
	bus_load_model u_load (.out_data, .out_en, .grounded, .mode_ground_n, .line);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one transfer; the request stands until pready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pins change together; ten edges outlast the sync and output stages
	task step(input logic [5:0] v, input logic [1:0] e);
		{strobe, grounded, disable_in, latch_clk, data_in_b, data_in_a} <= v;
		repeat (10) @(posedge core_clk);
		chk(line, e);
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		apb(1'b0, CTRL_OFF, 32'h0);
		chk(rd, {29'h0, CTRL_RESET});
		apb(1'b1, CTRL_OFF, 32'h7);
		apb(1'b0, CTRL_OFF, 32'h0);
		chk(rd, 32'h7);
		apb(1'b0, 8'h08, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, CTRL_OFF, 32'h0);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk({31'h0, rd[9]}, 32'h1);
		step(6'b100011, 2'h0);
		step(6'b000001, 2'h1);
		step(6'b000101, 2'h1);
		step(6'b000110, 2'h1);
		step(6'b001010, 2'h0);
		chk({30'h0, out_en}, 32'h1);
		step(6'b011010, 2'h2);
		step(6'b111010, 2'h0);
		finish_test;
	end
	// cut a hang short
	initial begin
		#20000;
		n_mismatch++;
		finish_test;
	end
endmodule

// *** verilog/bus_driver_pkg.sv ***
// package for the dual latched bus driver: register map, fields, sync depth
// assumes a 32-bit apb slave with byte addresses, one word per register
package bus_driver_pkg;
	localparam logic [7:0] CTRL_OFF      = 8'h00;  // mode, disable and strobe
	localparam logic [7:0] STATUS_OFF    = 8'h04;  // live pin and latch state
	localparam int         CTRL_MODE_BIT = 0;      // 1 = bus-level mode
	localparam int         CTRL_DIS_BIT  = 1;      // software disable
	localparam int         CTRL_STB_BIT  = 2;      // software strobe
	localparam logic [2:0] CTRL_RESET    = 3'h0;
	localparam int         CHANNELS      = 2;
	localparam int         SYNC_STAGES   = 3;
endpackage

// *** verilog/latched_bus_driver.sv ***
// dual-channel latched bus driver with apb control and status registers
// assumes pins are asynchronous and are synchronised here; apb on core_clk
`timescale 1ns/10ps
module latched_bus_driver (
	// clock and reset
	input  wire logic                                core_clk,
	input  wire logic                                sys_rst,
	// apb slave
	input  wire logic                                psel,
	input  wire logic                                penable,
	input  wire logic                                pwrite,
	input  wire logic [7:0]                          paddr,
	input  wire logic [31:0]                         pwdata,
	output logic      [31:0]                         prdata,
	output logic                                     pready,
	output logic                                     pslverr,
	// data and control pins
	input  wire logic                                data_in_a,
	input  wire logic                                data_in_b,
	input  wire logic                                latch_clk,
	input  wire logic                                strobe,
	input  wire logic                                disable_in,
	input  wire logic                                mode_ground_n,
	// driven outputs, three-state as out and enable
	output logic      [bus_driver_pkg::CHANNELS-1:0] out_data,
	output logic      [bus_driver_pkg::CHANNELS-1:0] out_en
);
	import bus_driver_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [5:0] pin_lvl;
	pin_sync #(.WIDTH(6)) u_sync (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.pin_in    ({mode_ground_n, disable_in, strobe, latch_clk, data_in_b, data_in_a}),
		.level_out (pin_lvl)
	);

	logic [CHANNELS-1:0] din;
	logic                lclk;
	logic                stb_pin;
	logic                dis_pin;
	logic                mode_pin_n;
	assign din        = pin_lvl[1:0];
	assign lclk       = pin_lvl[2];
	assign stb_pin    = pin_lvl[3];
	assign dis_pin    = pin_lvl[4];
	assign mode_pin_n = pin_lvl[5];

	////////////////////////////////////////////////////////////////////////////
	// control register and apb slave
	logic [2:0]  ctrl_reg;
	logic [2:0]  ctrl_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        pready_reg;
	logic        pready_next;
	logic        pslverr_reg;
	logic        pslverr_next;
	logic [CHANNELS-1:0] latch_reg;
	logic [CHANNELS-1:0] latch_next;
	logic [CHANNELS-1:0] od_reg;
	logic [CHANNELS-1:0] od_next;
	logic [CHANNELS-1:0] oe_reg;
	logic [CHANNELS-1:0] oe_next;
	logic        bus_mode;
	logic        dis_eff;
	logic        stb_eff;
	logic        access;
	logic        mapped;

	// one wait state: setup, access, answered on the second access edge
	// pready is registered, so it first reads high in the second access cycle and a transfer takes three edges
	assign access = psel && penable && !pready_reg;
	assign mapped = (paddr == CTRL_OFF) || (paddr == STATUS_OFF);

	always_comb begin
		ctrl_next    = ctrl_reg;
		prdata_next  = prdata_reg;
		pready_next  = 1'b0;
		pslverr_next = 1'b0;
		if (access) begin
			pready_next  = 1'b1;
			pslverr_next = !mapped;
			prdata_next  = 32'h0;
			if (pwrite && paddr == CTRL_OFF) begin
				ctrl_next = pwdata[2:0];
			end else if (!pwrite && paddr == CTRL_OFF) begin
				prdata_next = {29'h0, ctrl_reg};
			end else if (!pwrite && paddr == STATUS_OFF) begin
				// live state: outputs, enables, latches, effective mode and pins
				prdata_next = {20'h0, bus_mode, dis_eff, stb_eff, lclk,
					oe_reg, od_reg, latch_reg, din};
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ctrl_reg    <= CTRL_RESET;
			prdata_reg  <= 32'h0;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg    <= ctrl_next;
			prdata_reg  <= prdata_next;
			pready_reg  <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// mode, strobe and disable: pin or software bit, either one acts
	// the ctrl mode bit lets software pick bus mode when the pin is left open
	assign bus_mode = !mode_pin_n || ctrl_reg[CTRL_MODE_BIT];
	assign dis_eff  = dis_pin || ctrl_reg[CTRL_DIS_BIT];
	assign stb_eff  = stb_pin || ctrl_reg[CTRL_STB_BIT];

	////////////////////////////////////////////////////////////////////////////
	// per channel latch and output gating
	// the latch is sampled, so transparency lags the pin by the sync delay
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_chan
			always_comb begin
				if (!lclk) begin
					latch_next[g] = din[g];
				end else begin
					latch_next[g] = latch_reg[g];
				end
				if (stb_eff) begin
					od_next[g] = 1'b0;
					oe_next[g] = 1'b1;
				end else if (!bus_mode && dis_eff && latch_reg[g]) begin
					od_next[g] = 1'b0;
					oe_next[g] = 1'b0;
				end else begin
					od_next[g] = latch_reg[g];
					oe_next[g] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			latch_reg <= '0;
			od_reg    <= '0;
			oe_reg    <= '0;
		end else begin
			latch_reg <= latch_next;
			od_reg    <= od_next;
			oe_reg    <= oe_next;
		end
	end

	assign out_data = od_reg;
	assign out_en   = oe_reg;
	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;
endmodule

// *** verilog/pin_sync.sv ***
// three-stage synchroniser for asynchronous pins, one per bit
// assumes inputs are asynchronous to core_clk; change accepted when stages 2 and 3 agree
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// pins in, filtered level out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] lvl_reg;
	logic [WIDTH-1:0] lvl_next;

	// per bit: only take a new value when the two later stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
		end
	end

	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			s1_reg  <= '0;
			s2_reg  <= '0;
			s3_reg  <= '0;
			lvl_reg <= '0;
		end else begin
			s1_reg  <= pin_in;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_out = lvl_reg;
endmodule
